//--- verilog/gyr_register_map.sv
// Functional notes
// R1: x rate high at 0x23, low 0x24
// R2: z rate high at 0x25, low 0x26
// R3: temperature high at 0x29, low 0x2a
// R4: write to 0x3f clears parity; reads zero
// R5: queued samples drained through read-only 0x3e
// R6: 0x3c reports available samples, resets zero
// R7: bank 0 holds configuration, not interrupts
// R8: 0x01 filter config resets to 0x28
// R9: 0x16 interface config resets to zero
// R10: bank select at 0x21 maps low page
// R11: common bank 0x20-0x3f always reachable
// R12: read-only/reserved writes ignored, reserved read zero
`timescale 1ns/1ps
`default_nettype none
`include "gyr_consts.svh"
module gyr_register_map #(
  parameter logic [7:0] IDENTITY_CODE = 8'h5a  // arbitrary value
) (
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               reset,
  // register access from serial front end
  input  wire logic               regWrite,
  input  wire logic               regRead,
  input  wire gyr_pkg::gyr_addr_t regAddr,
  input  wire gyr_pkg::gyr_byte_t regWdata,
  output var  gyr_pkg::gyr_byte_t regRdata,
  // sensor results
  input  wire logic               sampleValid,
  input  wire logic [15:0]        rateX,
  input  wire logic [15:0]        rateZ,
  input  wire logic [15:0]        temperature,
  input  wire gyr_pkg::gyr_byte_t systemState,
  // queue fill side
  input  wire logic               queuePush,
  input  wire gyr_pkg::gyr_byte_t queueData,
  // configuration and control to the core
  output var  gyr_pkg::gyr_byte_t powerModeConfig,
  output var  gyr_pkg::gyr_byte_t filterStabilizationConfig,
  output var  gyr_pkg::gyr_byte_t outputRateConfig,
  output var  gyr_pkg::gyr_byte_t highpassConfig,
  output var  gyr_pkg::gyr_byte_t sampleReadyConfig,
  output var  gyr_pkg::gyr_byte_t pinIoConfig,
  output var  gyr_pkg::gyr_byte_t twoWireConfig,
  output var  gyr_pkg::gyr_byte_t interfaceOnetimeConfig,
  output var  gyr_pkg::gyr_byte_t queueThreshold,
  output var  gyr_pkg::gyr_byte_t queueModeConfig,
  output var  gyr_pkg::gyr_byte_t bankSelection,
  output logic                    highpassClearPulse,
  output logic                    parityClearPulse
);
  import gyr_pkg::*;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic       isCommon;
  logic       cfgBank;
  logic       cfgWrite;
  logic [4:0] lowAddr;
  gyr_byte_t  rdMux;
  gyr_byte_t  popData;
  logic [8:0] qLevel;
  logic       qLost;
  logic       queuePop;

  // common page never depends on the bank, so bank switching can't lock it out
  assign isCommon = regAddr[`GYR_COMMON_BIT];                        // see R11
  assign cfgBank  = bankSelection == `GYR_BANK_CFG;                  // see R10
  assign cfgWrite = regWrite && !isCommon && cfgBank;                // see R7
  assign lowAddr  = regAddr[4:0];

  // ---------------------------------------------------------------
  // configuration bank
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      powerModeConfig           <= `GYR_R_POWER_CFG;
      filterStabilizationConfig <= `GYR_R_FILTER_CFG;                // see R8
      outputRateConfig          <= `GYR_R_RATE_CFG;
      highpassConfig            <= `GYR_R_ZERO;
      sampleReadyConfig         <= `GYR_R_READY_CFG;
      pinIoConfig               <= `GYR_R_ZERO;
      twoWireConfig             <= `GYR_R_TWO_WIRE_CFG;
      interfaceOnetimeConfig    <= `GYR_R_ZERO;                      // see R9
      queueThreshold            <= `GYR_R_ZERO;
      queueModeConfig           <= `GYR_R_ZERO;
    end else if (cfgWrite) begin
      case (lowAddr)
        `GYR_A_POWER_CFG:    powerModeConfig <= regWdata;
        `GYR_A_FILTER_CFG:   filterStabilizationConfig <= regWdata;  // see R8
        `GYR_A_RATE_CFG:     outputRateConfig <= regWdata;
        `GYR_A_HP_CFG:       highpassConfig <= regWdata;
        `GYR_A_READY_CFG:    sampleReadyConfig <= regWdata;
        `GYR_A_PIN_IO_CFG:   pinIoConfig <= regWdata;
        `GYR_A_TWO_WIRE_CFG: twoWireConfig <= regWdata;
        `GYR_A_INTERFACE_ONETIME_CONFIG_CFG:  interfaceOnetimeConfig <= regWdata;     // see R9
        `GYR_A_QUEUE_THR:    queueThreshold <= regWdata;
        `GYR_A_QUEUE_MODE:   queueModeConfig <= regWdata;
        default: ;                                                   // see R12
      endcase
    end
  end

  // ---------------------------------------------------------------
  // common bank writable locations
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      bankSelection <= `GYR_R_ZERO;
    end else if (regWrite && regAddr == `GYR_A_BANK_SEL) begin
      bankSelection <= regWdata;                                     // see R10
    end
  end

  // clear registers are strobes only; nothing is stored
  always_ff @(posedge core_clk) begin
    if (reset) begin
      highpassClearPulse <= 1'b0;
      parityClearPulse   <= 1'b0;
    end else begin
      highpassClearPulse <= regWrite && regAddr == `GYR_A_HP_CLEAR;
      parityClearPulse   <= regWrite && regAddr == `GYR_A_PARITY_CLEAR; // see R4
    end
  end

  // ---------------------------------------------------------------
  // result snapshot
  // ---------------------------------------------------------------
  logic [15:0] rateX_q;
  logic [15:0] rateZ_q;
  logic [15:0] temp_q;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rateX_q <= 16'h0000;
      rateZ_q <= 16'h0000;
      temp_q  <= 16'h0000;
    end else if (sampleValid) begin
      rateX_q <= rateX;                                              // see R1
      rateZ_q <= rateZ;                                              // see R2
      temp_q  <= temperature;                                        // see R3
    end
  end

  // ---------------------------------------------------------------
  // sample queue
  // ---------------------------------------------------------------
  assign queuePop = regRead && regAddr == `GYR_A_QUEUE_PORT;         // see R5

  gyr_sample_queue uQueue (
    .core_clk  (core_clk),
    .reset     (reset),
    .pushValid (queuePush),
    .pushData  (queueData),
    .popReq    (queuePop),
    .popData   (popData),
    .level     (qLevel),
    .lost      (qLost)
  );

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    rdMux = `GYR_R_ZERO;                                             // see R12
    if (isCommon) begin
      case (regAddr)
        `GYR_A_IDENTITY:     rdMux = IDENTITY_CODE;
        `GYR_A_BANK_SEL:     rdMux = bankSelection;
        `GYR_A_SYS_STATE:    rdMux = systemState;
        `GYR_A_RATE_X_HIGH:  rdMux = rateX_q[15:8];                  // see R1
        `GYR_A_RATE_X_LOW:   rdMux = rateX_q[7:0];                   // see R1
        `GYR_A_RATE_Z_HIGH:  rdMux = rateZ_q[15:8];                  // see R2
        `GYR_A_RATE_Z_LOW:   rdMux = rateZ_q[7:0];                   // see R2
        `GYR_A_TEMP_HIGH:    rdMux = temp_q[15:8];                   // see R3
        `GYR_A_TEMP_LOW:     rdMux = temp_q[7:0];                    // see R3
        // level saturates: 256 entries do not fit a byte
        `GYR_A_QUEUE_LEVEL:  rdMux = qLevel[8] ? 8'hff : qLevel[7:0]; // see R6
        `GYR_A_QUEUE_FLAGS:  rdMux = {5'h00, qLost, qLevel[8], qLevel == 9'h000};
        `GYR_A_QUEUE_PORT:   rdMux = popData;                        // see R5
        `GYR_A_PARITY_CLEAR: rdMux = `GYR_R_ZERO;                    // see R4
        default:             rdMux = `GYR_R_ZERO;
      endcase
    end else if (cfgBank) begin
      case (lowAddr)
        `GYR_A_POWER_CFG:    rdMux = powerModeConfig;
        `GYR_A_FILTER_CFG:   rdMux = filterStabilizationConfig;
        `GYR_A_RATE_CFG:     rdMux = outputRateConfig;
        `GYR_A_HP_CFG:       rdMux = highpassConfig;
        `GYR_A_READY_CFG:    rdMux = sampleReadyConfig;
        `GYR_A_PIN_IO_CFG:   rdMux = pinIoConfig;
        `GYR_A_TWO_WIRE_CFG: rdMux = twoWireConfig;
        `GYR_A_INTERFACE_ONETIME_CONFIG_CFG:  rdMux = interfaceOnetimeConfig;
        `GYR_A_QUEUE_THR:    rdMux = queueThreshold;
        `GYR_A_QUEUE_MODE:   rdMux = queueModeConfig;
        default:             rdMux = `GYR_R_ZERO;                    // see R12
      endcase
    end
  end

  // read data registered; queue byte is the head before the pop
  always_ff @(posedge core_clk) begin
    if (reset) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      regRdata <= rdMux;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_filter_reset;
    @(posedge core_clk) $fell(reset) |-> filterStabilizationConfig == 8'h28;
  endproperty
  a_filter_reset: assert property (p_filter_reset) else $error("filter reset value"); // see R8

  property p_otp_reset;
    @(posedge core_clk) $fell(reset) |-> interfaceOnetimeConfig == 8'h00;
  endproperty
  a_otp_reset: assert property (p_otp_reset) else $error("otp reset value"); // see R9

  property p_parity_pulse;
    @(posedge core_clk) disable iff (reset)
      regWrite && regAddr == 6'h3f |=> parityClearPulse;
  endproperty
  a_parity_pulse: assert property (p_parity_pulse) else $error("parity clear missing"); // see R4

  property p_parity_read;
    @(posedge core_clk) disable iff (reset)
      regRead && regAddr == 6'h3f |=> regRdata == 8'h00;
  endproperty
  a_parity_read: assert property (p_parity_read) else $error("parity reads nonzero"); // see R4

  property p_x_high;
    @(posedge core_clk) disable iff (reset)
      regRead && regAddr == 6'h23 |=> regRdata == $past(rateX_q[15:8]);
  endproperty
  a_x_high: assert property (p_x_high) else $error("x high byte wrong"); // see R1

  property p_z_low;
    @(posedge core_clk) disable iff (reset)
      regRead && regAddr == 6'h26 |=> regRdata == $past(rateZ_q[7:0]);
  endproperty
  a_z_low: assert property (p_z_low) else $error("z low byte wrong"); // see R2

  sequence s_capture;
    sampleValid ##1 !sampleValid;
  endsequence
  property p_temp_high;
    @(posedge core_clk) disable iff (reset)
      s_capture ##1 (regRead && regAddr == `GYR_A_TEMP_HIGH && !sampleValid)
        |=> regRdata == $past(temperature[15:8], 3);
  endproperty
  a_temp_high: assert property (p_temp_high) else $error("temp high wrong"); // see R3

  property p_level_zero;
    @(posedge core_clk) $fell(reset) |-> qLevel == 9'h000;
  endproperty
  a_level_zero: assert property (p_level_zero) else $error("level not zero"); // see R6

  // a write into the unmapped low page must leave the bank 0 power and filter configs untouched
  sequence s_unmapped_write;
    regWrite && !regAddr[`GYR_COMMON_BIT] && bankSelection != `GYR_BANK_CFG;
  endsequence
  property p_bank_block;
    @(posedge core_clk) disable iff (reset)
      s_unmapped_write |=> $stable(filterStabilizationConfig) && $stable(powerModeConfig);
  endproperty
  a_bank_block: assert property (p_bank_block) else $error("bank 0 written while unmapped"); // see R10

  property p_common_id;
    @(posedge core_clk) disable iff (reset)
      regRead && regAddr == 6'h20 |=> regRdata == IDENTITY_CODE;
  endproperty
  a_common_id: assert property (p_common_id) else $error("identity unreachable"); // see R11

  property p_bank_write;
    @(posedge core_clk) disable iff (reset)
      regWrite && regAddr == `GYR_A_BANK_SEL |=> bankSelection == $past(regWdata);
  endproperty
  a_bank_write: assert property (p_bank_write) else $error("bank selection not taken"); // see R10

  property p_unmapped_read;
    @(posedge core_clk) disable iff (reset)
      regRead && !regAddr[`GYR_COMMON_BIT] && bankSelection != `GYR_BANK_CFG
        |=> regRdata == `GYR_R_ZERO;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped page not zero"); // see R10

  property p_level_saturate;
    @(posedge core_clk) disable iff (reset)
      regRead && regAddr == `GYR_A_QUEUE_LEVEL && qLevel[8] |=> regRdata == 8'hff;
  endproperty
  a_level_saturate: assert property (p_level_saturate) else $error("full level wrong"); // see R6

  property p_reserved_zero;
    @(posedge core_clk) disable iff (reset)
      regRead && (regAddr == 6'h27 || regAddr == 6'h30) |=> regRdata == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved nonzero"); // see R12

  property p_pop_level;
    @(posedge core_clk) disable iff (reset)
      queuePop && !queuePush && qLevel != 9'h000 |=> qLevel == $past(qLevel) - 9'h001;
  endproperty
  a_pop_level: assert property (p_pop_level) else $error("queue read did not drain"); // see R5
endmodule : gyr_register_map
`default_nettype wire

//--- verilog/gyr_consts.svh
`ifndef GYR_CONSTS_SVH
`define GYR_CONSTS_SVH

// ---------------------------------------------------------------
// common bank offsets
// ---------------------------------------------------------------
`define GYR_A_IDENTITY      6'h20
`define GYR_A_BANK_SEL      6'h21
`define GYR_A_SYS_STATE     6'h22
`define GYR_A_RATE_X_HIGH   6'h23
`define GYR_A_RATE_X_LOW    6'h24
`define GYR_A_RATE_Z_HIGH   6'h25
`define GYR_A_RATE_Z_LOW    6'h26
`define GYR_A_TEMP_HIGH     6'h29
`define GYR_A_TEMP_LOW      6'h2a
`define GYR_A_HP_CLEAR      6'h3b
`define GYR_A_QUEUE_LEVEL   6'h3c
`define GYR_A_QUEUE_FLAGS   6'h3d
`define GYR_A_QUEUE_PORT    6'h3e
`define GYR_A_PARITY_CLEAR  6'h3f

// ---------------------------------------------------------------
// user bank 0 offsets and reset values
// ---------------------------------------------------------------
`define GYR_A_POWER_CFG     5'h00
`define GYR_A_FILTER_CFG    5'h01
`define GYR_A_RATE_CFG      5'h02
`define GYR_A_HP_CFG        5'h03
`define GYR_A_READY_CFG     5'h13
`define GYR_A_PIN_IO_CFG    5'h14
`define GYR_A_TWO_WIRE_CFG  5'h15
`define GYR_A_INTERFACE_ONETIME_CONFIG_CFG   5'h16
`define GYR_A_QUEUE_THR     5'h17
`define GYR_A_QUEUE_MODE    5'h18
`define GYR_A_SYNC_CFG      5'h1a
`define GYR_A_SYNC_COUNT    5'h1b

`define GYR_R_POWER_CFG     8'h07
`define GYR_R_FILTER_CFG    8'h28
`define GYR_R_RATE_CFG      8'h23
`define GYR_R_READY_CFG     8'h01
`define GYR_R_TWO_WIRE_CFG  8'h04
`define GYR_R_ZERO          8'h00

// ---------------------------------------------------------------
// misc layout
// ---------------------------------------------------------------
`define GYR_COMMON_BIT      5
`define GYR_BANK_CFG        8'h00
`define GYR_QUEUE_DEPTH     256
`define GYR_QUEUE_AW        8
`define GYR_FLAG_EMPTY      0
`define GYR_FLAG_FULL       1
`define GYR_FLAG_LOST       2

`endif

//--- verilog/gyr_pkg.sv
package gyr_pkg;
  typedef logic [7:0] gyr_byte_t;
  typedef logic [5:0] gyr_addr_t;
endpackage : gyr_pkg

//--- verilog/gyr_sample_queue.sv
`timescale 1ns/1ps
`default_nettype none
`include "gyr_consts.svh"
module gyr_sample_queue (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset,
  // push side
  input  wire logic             pushValid,
  input  wire gyr_pkg::gyr_byte_t pushData,
  // pop side
  input  wire logic             popReq,
  output var  gyr_pkg::gyr_byte_t popData,
  output var  logic [8:0]       level,
  output var  logic             lost
);
  import gyr_pkg::*;

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  gyr_byte_t                 mem [`GYR_QUEUE_DEPTH];
  logic [`GYR_QUEUE_AW-1:0]  wrPtr_q;
  logic [`GYR_QUEUE_AW-1:0]  rdPtr_q;
  logic [8:0]                count_q;
  logic                      doPop;
  logic                      doPush;

  // full queue drops new data unless a pop frees a place in the same cycle, a read of an empty queue is a no-op
  assign doPop  = popReq && (count_q != 9'h000);
  assign doPush = pushValid && (count_q != 9'h100 || doPop);

  always_ff @(posedge core_clk) begin
    if (doPush) begin
      mem[wrPtr_q] <= pushData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      wrPtr_q <= 8'h00;
      rdPtr_q <= 8'h00;
      count_q <= 9'h000;
    end else begin
      if (doPush) begin
        wrPtr_q <= wrPtr_q + 8'h01;
      end
      if (doPop) begin
        rdPtr_q <= rdPtr_q + 8'h01;
      end
      count_q <= count_q + {8'h00, doPush} - {8'h00, doPop};
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      lost <= 1'b0;
    end else if (pushValid && !doPush) begin
      lost <= 1'b1;
    end else if (doPop && count_q == 9'h001) begin
      lost <= 1'b0;
    end
  end

  // head shown without a register stage so a byte pushed one cycle
  // earlier is already readable
  assign popData = mem[rdPtr_q];
  assign level   = count_q;
endmodule : gyr_sample_queue
`default_nettype wire

//--- sim/gyr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module gyr_host_model (
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               reset,
  // register strobes toward the map
  output var  logic               regWrite,
  output var  logic               regRead,
  output var  gyr_pkg::gyr_addr_t regAddr,
  output var  gyr_pkg::gyr_byte_t regWdata,
  // read answer
  input  wire gyr_pkg::gyr_byte_t regRdata
);
  import gyr_pkg::*;

  // ---------------------------------------------------------------
  // idle state
  // ---------------------------------------------------------------
  initial begin
    regWrite = 1'b0;
    regRead  = 1'b0;
    regAddr  = 6'h00;
    regWdata = 8'h00;
  end

  // ---------------------------------------------------------------
  // one access per call, always an idle cycle between calls
  // ---------------------------------------------------------------
  // bank selection writes go through here like any other write
  task automatic wr(input gyr_addr_t a, input gyr_byte_t d);
    @(negedge core_clk);
    regAddr  = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge core_clk);
    regWrite = 1'b0;
    // released lines flip so a stale value never looks valid
    regAddr  = ~a;
    regWdata = ~d;
  endtask : wr

  // queue drain is repeated reads of one location
  task automatic rd(input gyr_addr_t a, output gyr_byte_t d);
    @(negedge core_clk);
    regAddr = a;
    regRead = 1'b1;
    @(negedge core_clk);
    d       = regRdata;
    regRead = 1'b0;
    regAddr = ~a;
  endtask : rd
endmodule : gyr_host_model
`default_nettype wire

//--- sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import gyr_pkg::*;

  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam logic [7:0] IdCode = 8'h3c;  // arbitrary value
  logic        core_clk, reset, regWrite, regRead, sampleValid, queuePush;
  gyr_addr_t   regAddr;
  gyr_byte_t   regWdata, regRdata, systemState, queueData, v, lfsrState;
  logic [15:0] rateX, rateZ, temperature;
  gyr_byte_t   cfg [11];
  logic        hpPulse, parPulse;
  gyr_byte_t   shadow [32];
  gyr_byte_t   sb [6];
  int          err_count, total_checks, cycles, i;

  gyr_host_model gyr_host_model_i (.core_clk(core_clk), .reset(reset), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata));

  gyr_register_map #(.IDENTITY_CODE(IdCode)) gyr_register_map_i (.core_clk(core_clk),
    .reset(reset), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .sampleValid(sampleValid), .rateX(rateX),
    .rateZ(rateZ), .temperature(temperature), .systemState(systemState),
    .queuePush(queuePush), .queueData(queueData), .powerModeConfig(cfg[0]),
    .filterStabilizationConfig(cfg[1]), .outputRateConfig(cfg[2]), .highpassConfig(cfg[3]),
    .sampleReadyConfig(cfg[4]), .pinIoConfig(cfg[5]), .twoWireConfig(cfg[6]),
    .interfaceOnetimeConfig(cfg[7]), .queueThreshold(cfg[8]), .queueModeConfig(cfg[9]),
    .bankSelection(cfg[10]), .highpassClearPulse(hpPulse), .parityClearPulse(parPulse));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic gyr_byte_t lfsrNext(input gyr_byte_t s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsrNext

  function automatic gyr_byte_t bank0Reset(input int a);
    case (a)
      'h00: return 8'h07;
      'h01: return 8'h28;
      'h02: return 8'h23;
      'h13: return 8'h01;
      'h15: return 8'h04;
      default: return 8'h00;
    endcase
  endfunction : bank0Reset

  function automatic bit isRw(input int a);
    return (a <= 'h03) || (a >= 'h13 && a <= 'h18);
  endfunction : isRw

  task automatic rnd(output gyr_byte_t r);
    lfsrState = lfsrNext(lfsrState);
    r = lfsrState;
  endtask : rnd

  task automatic chk(input string what, input gyr_byte_t exp, input gyr_byte_t got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic rc(input gyr_addr_t a, input gyr_byte_t exp, input string what);
    gyr_byte_t d;
    gyr_host_model_i.rd(a, d);
    chk(what, exp, d);
  endtask : rc

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results

  // ---------------------------------------------------------------
  // clock, reset and hang guard
  // ---------------------------------------------------------------
  always #5 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 8000) begin
      err_count++;
      results();
    end
  end

  initial begin
    core_clk = 1'b0;
    reset = 1'b1;
    {sampleValid, queuePush, queueData, rateX, rateZ, temperature} = '0;
    lfsrState = 8'h1d;
    systemState = 8'h00;
    repeat (6) @(negedge core_clk);
    rnd(systemState);
    reset = 1'b0;
    // reset values of the configuration page
    for (i = 0; i < 32; i++) rc(i[5:0], bank0Reset(i), "bank0 reset");
    rc(6'h20, IdCode, "identity");
    rc(6'h21, 8'h00, "bank reset");
    rc(6'h22, systemState, "system state");
    rc(6'h3c, 8'h00, "level reset");
    rc(6'h3f, 8'h00, "parity reads");
    // random writes everywhere on the page; only rw places keep them
    for (i = 0; i < 32; i++) begin
      rnd(v);
      gyr_host_model_i.wr(i[5:0], v);
      shadow[i] = isRw(i) ? v : bank0Reset(i);
    end
    for (i = 0; i < 32; i++) rc(i[5:0], shadow[i], "bank0 rw");
    chk("filter out", shadow[1], cfg[1]);
    chk("itf out", shadow['h16], cfg[7]);
    for (i = 0; i < 10; i++) chk("config out", shadow[i < 4 ? i : i + 'h0f], cfg[i]);
    // reserved common places ignore writes and read zero
    for (i = 'h27; i < 'h3b; i++) begin
      if (i > 'h28 && i < 'h2b) continue;
      rnd(v);
      gyr_host_model_i.wr(i[5:0], v);
      rc(i[5:0], 8'h00, "reserved");
    end
    // sample snapshot, then move the inputs without a capture
    for (i = 0; i < 6; i++) rnd(sb[i]);
    @(negedge core_clk);
    {rateX, rateZ, temperature} = {sb[0], sb[1], sb[2], sb[3], sb[4], sb[5]};
    sampleValid = 1'b1;
    @(negedge core_clk);
    sampleValid = 1'b0;
    {rateX, rateZ, temperature} = ~{sb[0], sb[1], sb[2], sb[3], sb[4], sb[5]};
    rc(6'h29, sb[4], "t high");
    gyr_host_model_i.wr(6'h23, ~sb[0]);
    rc(6'h23, sb[0], "x high");
    rc(6'h24, sb[1], "x low");
    rc(6'h25, sb[2], "z high");
    rc(6'h26, sb[3], "z low");
    rc(6'h2a, sb[5], "t low");
    // write-to-clear places give one pulse and read zero
    gyr_host_model_i.wr(6'h3f, 8'h00);
    chk("parity pulse", 8'h01, {7'h00, parPulse});
    @(negedge core_clk);
    chk("parity pulse end", 8'h00, {7'h00, parPulse});
    gyr_host_model_i.wr(6'h3b, 8'hff);
    chk("hp pulse", 8'h01, {7'h00, hpPulse});
    rc(6'h3f, 8'h00, "parity after write");
    // queue fill back to back, then drain with an idle cycle between reads
    for (i = 0; i < 6; i++) begin
      rnd(sb[i]);
      @(negedge core_clk);
      queuePush = 1'b1;
      queueData = sb[i];
    end
    @(negedge core_clk);
    queuePush = 1'b0;
    queueData = ~queueData;
    rc(6'h3c, 8'h06, "level");
    for (i = 0; i < 6; i++) rc(6'h3e, sb[i], "queue data");
    rc(6'h3c, 8'h00, "level drained");
    gyr_host_model_i.rd(6'h3d, v);
    chk("empty flag", 8'h01, v & 8'h01);
    // second page selected: low page gone, common page stays
    gyr_host_model_i.wr(6'h21, 8'h01);
    chk("bank out", 8'h01, cfg[10]);
    rc(6'h01, 8'h00, "low page unmapped");
    gyr_host_model_i.wr(6'h01, 8'h55);
    rc(6'h23, sb[0] ^ sb[0] ^ ~rateX[15:8], "common kept");
    rc(6'h20, IdCode, "identity kept");
    gyr_host_model_i.wr(6'h21, 8'h00);
    rc(6'h01, shadow[1], "low page back");
    // overfill: the last byte is dropped and flagged
    for (i = 0; i < 257; i++) begin
      rnd(v);
      @(negedge core_clk);
      queuePush = 1'b1;
      queueData = v;
    end
    @(negedge core_clk);
    queuePush = 1'b0;
    rc(6'h3c, 8'hff, "level full");
    rc(6'h3d, 8'h06, "flags full");
    // reset again mid run
    @(negedge core_clk);
    reset = 1'b1;
    repeat (2) @(negedge core_clk);
    reset = 1'b0;
    rc(6'h01, 8'h28, "filter reset");
    rc(6'h16, 8'h00, "itf reset");
    rc(6'h3c, 8'h00, "level after reset");
    rc(6'h3d, 8'h01, "flags after reset");
    results();
  end
endmodule : tb
`default_nettype wire
